// File: gshp_consts.svh
// Named constants for the gas sensor host port: addresses, codes, timing.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef GSHP_CONSTS_SVH
`define GSHP_CONSTS_SVH

// Upper six bits of the 7-bit target address; pin gives the LSB
`define GSHP_ADDR_HI6 6'h29
// Register byte addresses
`define GSHP_REG_TEMP_L 8'h13
`define GSHP_REG_TEMP_H 8'h14
`define GSHP_REG_RH_L 8'h15
`define GSHP_REG_RH_H 8'h16
`define GSHP_REG_STATUS 8'h20
// Validity field position inside the state report
`define GSHP_VALID_LSB 2
// Validity codes
`define GSHP_VAL_OK 2'h0
`define GSHP_VAL_WARMUP 2'h1
`define GSHP_VAL_STARTUP 2'h2
`define GSHP_VAL_INVALID 2'h3
// Bits per serial byte
`define GSHP_BYTE_BITS 4'h8
// Timing: clock rate and times in their own units
`define GSHP_CLK_HZ 200000000
`define GSHP_WARMUP_MIN 3
`define GSHP_STARTUP_HR 1
`define GSHP_COMMIT_HR 24
`define GSHP_SEC_PER_MIN 60
`define GSHP_SEC_PER_HR 3600
// Seconds counter width, wide enough for the commit time
`define GSHP_SEC_W 17

`endif

// File: gshp_host_bfm.sv
// Host model for the serial link: a bus master on the open-drain pins.
// Assumes a pull-up on the data line; the bench merges both pull-downs.
`timescale 1ns/1ps
`default_nettype none

module gshp_host_bfm (
  input wire logic mclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  // Idle bus: clock high, data released
  initial
  begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick

  // START or repeated START; four cycles a phase keeps above the 3-cycle floor
  task automatic start_cond();
    tick(1);
    sda_pull_o <= 1'b0;
    tick(3);
    scl_o <= 1'b1;
    tick(4);
    sda_pull_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
  endtask : start_cond

  // Data rises while clock high
  task automatic stop_cond();
    tick(1);
    sda_pull_o <= 1'b1;
    tick(3);
    scl_o <= 1'b1;
    tick(4);
    sda_pull_o <= 1'b0;
    tick(4);
  endtask : stop_cond

  // One clock pulse; data changes only while the clock is low
  task automatic bit_xfer(input logic b, output logic s);
    tick(1);
    sda_pull_o <= ~b;
    tick(3);
    scl_o <= 1'b1;
    tick(2);
    s = sda_i;
    tick(2);
    scl_o <= 1'b0;
  endtask : bit_xfer

  // MSB first, then the target's acknowledge slot
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_xfer(b[i], s);
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask : wbyte

  // Host acknowledges while more bytes are wanted
  task automatic rbyte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_xfer(1'b1, b[i]);
    bit_xfer(~more, s);
  endtask : rbyte
endmodule : gshp_host_bfm

`default_nettype wire

// File: gshp_pkg.sv
// Types shared by the gas sensor host port modules.
// Assumes the constants header is compiled alongside.
`default_nettype none
package gshp_pkg;

  // Serial target sequencing
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK,
    ST_RDATA_NEXT
  } gshp_i2c_state_t;

endpackage : gshp_pkg
`default_nettype wire

// File: gshp_stat_if.sv
// Carrier between the status timer and the host port top.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface gshp_stat_if;
  logic [1:0] validity;
  logic startup_commit;
  modport src (output validity, output startup_commit);
  modport snk (input validity, input startup_commit);
endinterface : gshp_stat_if

`default_nettype wire

// File: gshp_status.sv
// Validity code generation and start-up completion commit.
// Assumes nvm_startup_done_i is stable from reset release onward.
`timescale 1ns/1ps
`default_nettype none
`include "gshp_consts.svh"

module gshp_status
  import gshp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `GSHP_CLK_HZ,
  parameter int unsigned WARMUP_S = `GSHP_WARMUP_MIN * `GSHP_SEC_PER_MIN,
  parameter int unsigned STARTUP_S = `GSHP_STARTUP_HR * `GSHP_SEC_PER_HR,
  parameter int unsigned COMMIT_S = `GSHP_COMMIT_HR * `GSHP_SEC_PER_HR
)
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic nvm_startup_done_i,
  input wire logic out_of_range_i,
  gshp_stat_if.src st
);

  logic [31:0] tick_cnt;
  logic [31:0] next_tick_cnt;
  logic [`GSHP_SEC_W-1:0] sec;
  logic [`GSHP_SEC_W-1:0] next_sec;
  logic caught;
  logic next_caught;
  logic need_startup;
  logic next_need_startup;
  logic committed;
  logic next_committed;
  logic commit;
  logic next_commit;
  logic [1:0] vld;
  logic [1:0] next_vld;

  // Seconds since power-on, saturating at the commit time
  always_comb
  begin
    next_tick_cnt = tick_cnt + 32'h1;
    next_sec = sec;
    next_caught = 1'b1;
    next_need_startup = need_startup;
    next_committed = committed;
    next_commit = 1'b0;
    if (tick_cnt == TICK_CYCLES - 1)
    begin
      next_tick_cnt = 32'h0;
      if (sec != `GSHP_SEC_W'(COMMIT_S))
        next_sec = sec + `GSHP_SEC_W'(1);
    end
    // NVM flag is caught once after release, not in reset
    if (!caught)
      next_need_startup = ~nvm_startup_done_i;
    // Commit only after the full continuous run time
    if (caught && need_startup && !committed && sec == `GSHP_SEC_W'(COMMIT_S))
    begin
      next_commit = 1'b1;
      next_committed = 1'b1;
    end
    // Out-of-range beats the timed phases
    if (out_of_range_i)
      next_vld = `GSHP_VAL_INVALID;
    // Before the NVM flag is caught, read it directly so a recorded
    // start-up never shows code 2, not even for the first cycle
    else if ((caught ? need_startup : ~nvm_startup_done_i) && sec < `GSHP_SEC_W'(STARTUP_S))
      next_vld = `GSHP_VAL_STARTUP;
    else if (sec < `GSHP_SEC_W'(WARMUP_S))
      next_vld = `GSHP_VAL_WARMUP;
    else
      next_vld = `GSHP_VAL_OK;
  end

  // Status registers; unknown NVM state assumed to need start-up
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tick_cnt <= 32'h0;
      sec <= '0;
      caught <= 1'b0;
      need_startup <= 1'b1;
      committed <= 1'b0;
      commit <= 1'b0;
      vld <= `GSHP_VAL_WARMUP;
    end
    else
    begin
      tick_cnt <= next_tick_cnt;
      sec <= next_sec;
      caught <= next_caught;
      need_startup <= next_need_startup;
      committed <= next_committed;
      commit <= next_commit;
      vld <= next_vld;
    end
  end

  assign st.validity = vld;
  assign st.startup_commit = commit;

endmodule : gshp_status

`default_nettype wire

// File: gshp_top.sv
// Host interface of the gas sensor: I2C target, SPI-side register port,
// shared register map, validity reporting, baseline and NVM handshakes.
// Assumes all pins are synchronous to mclk_i; the SPI serial engine sits
// outside and uses the byte-wide register port here.
// Notes on behaviour
// - Interface select pin high keeps the host interface an I2C target.
// - Address pin sampled after power-up sets address LSB: 0x52 or 0x53.
// - Select pin low once switches to SPI until the next power-on reset.
// - Both interfaces reach the very same register map.
// - Works at 100k, 400k and 1M bit rates by edge sampling.
// - Detects START and STOP, matches 7-bit address, drives acknowledge bits.
// - No 10-bit address, general call, software reset or device ID.
// - No master features: no clock sync, arbitration or START byte.
// - Register pointer advances after every data byte, read or written.
// - Validity reads 1 for three minutes after power-on, else 0.
// - Validity reads 2 for the first hour of every run until start-up completion is recorded in NVM.
// - Validity reads 3 when sensing elements are out of range.
// - Start-up completion goes to NVM only after 24 hours running.
// - Baseline is saved to NVM and reloaded after every power-up.
// - Compensation applies to processed outputs by default, not raw values.
// - Read: write-address, pointer, restart, read-address, bytes until STOP.
`timescale 1ns/1ps
`default_nettype none
`include "gshp_consts.svh"

module gshp_top
  import gshp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `GSHP_CLK_HZ,
  parameter int unsigned WARMUP_S = `GSHP_WARMUP_MIN * `GSHP_SEC_PER_MIN,
  parameter int unsigned STARTUP_S = `GSHP_STARTUP_HR * `GSHP_SEC_PER_HR,
  parameter int unsigned COMMIT_S = `GSHP_COMMIT_HR * `GSHP_SEC_PER_HR
)
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic interface_select_n_i,
  input wire logic addr_sel_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic spi_mode_o,
  input wire logic [7:0] spi_addr_i,
  input wire logic spi_wr_i,
  input wire logic [7:0] spi_wdata_i,
  output logic [7:0] spi_rdata_o,
  input wire logic nvm_startup_done_i,
  output logic nvm_startup_commit_o,
  input wire logic out_of_range_i,
  input wire logic [15:0] baseline_i,
  input wire logic baseline_valid_i,
  output logic nvm_baseline_wr_o,
  output logic [15:0] nvm_baseline_o,
  output logic baseline_reload_o,
  output logic [15:0] comp_temp_o,
  output logic [15:0] comp_rh_o,
  output logic comp_processed_en_o,
  output logic comp_raw_en_o
);

  gshp_stat_if st_if ();

  // Validity and lifetime start-up tracking
  gshp_status #(
    .TICK_CYCLES (TICK_CYCLES),
    .WARMUP_S (WARMUP_S),
    .STARTUP_S (STARTUP_S),
    .COMMIT_S (COMMIT_S)
  ) u_status (
    .mclk_i (mclk_i),
    .rst_n_i (rst_n_i),
    .nvm_startup_done_i (nvm_startup_done_i),
    .out_of_range_i (out_of_range_i),
    .st (st_if.src)
  );

  gshp_i2c_state_t state;
  gshp_i2c_state_t next_state;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic rw;
  logic next_rw;
  logic drv;
  logic next_drv;
  logic i2c_wr;
  logic scl_q;
  logic sda_q;
  logic scl_p;
  logic sda_p;
  logic spi_mode;
  logic next_spi_mode;
  logic addr_lsb;
  logic next_addr_lsb;
  logic booted;
  logic next_booted;
  logic reload;
  logic next_reload;
  logic bl_wr;
  logic next_bl_wr;
  logic [15:0] bl_data;
  logic [15:0] next_bl_data;
  logic [15:0] temp_reg;
  logic [15:0] next_temp_reg;
  logic [15:0] rh_reg;
  logic [15:0] next_rh_reg;
  logic [7:0] spi_rdata;
  logic [7:0] next_spi_rdata;
  logic [7:0] stat_byte;
  logic [6:0] own_addr;
  logic i2c_on;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic byte_done;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  // One map serves both hosts; unmapped bytes read zero
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    case (a)
      `GSHP_REG_TEMP_L: rd_byte = temp_reg[7:0];
      `GSHP_REG_TEMP_H: rd_byte = temp_reg[15:8];
      `GSHP_REG_RH_L: rd_byte = rh_reg[7:0];
      `GSHP_REG_RH_H: rd_byte = rh_reg[15:8];
      `GSHP_REG_STATUS: rd_byte = stat_byte;
      default: rd_byte = 8'h00;
    endcase
  endfunction : rd_byte

  // Line events from registered samples; pins are already synchronous
  assign start_det = scl_q & scl_p & sda_p & ~sda_q;
  assign stop_det = scl_q & scl_p & ~sda_p & sda_q;
  assign scl_rise = scl_q & ~scl_p;
  assign scl_fall = ~scl_q & scl_p;
  assign byte_done = (bitcnt == `GSHP_BYTE_BITS);
  assign own_addr = {`GSHP_ADDR_HI6, addr_lsb};
  // Serial target only while select is high and SPI was never chosen
  assign i2c_on = interface_select_n_i & ~spi_mode;
  assign stat_byte = {6'h00, st_if.validity} << `GSHP_VALID_LSB;

  // Serial target sequencing: bits sampled on rise, driven after fall
  always_comb
  begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_rw = rw;
    next_drv = drv;
    i2c_wr = 1'b0;
    if (!i2c_on || stop_det)
    begin
      next_state = ST_IDLE;
      next_drv = 1'b0;
    end
    else if (start_det)
    begin
      // Repeated start lands here too, pointer is kept
      next_state = ST_ADDR;
      next_bitcnt = 4'h0;
      next_drv = 1'b0;
    end
    else if (scl_rise)
    begin
      case (state)
        ST_ADDR, ST_PTR, ST_WDATA:
        begin
          next_shreg = {shreg[6:0], sda_q};
          next_bitcnt = bitcnt + 4'h1;
        end
        ST_RDATA:
          next_bitcnt = bitcnt + 4'h1;
        ST_RDATA_ACK:
          // Host not-acknowledge ends the read phase
          next_state = sda_q ? ST_IDLE : ST_RDATA_NEXT;
        default:
          next_state = state;
      endcase
    end
    else if (scl_fall)
    begin
      case (state)
        ST_ADDR:
        begin
          if (byte_done)
          begin
            next_bitcnt = 4'h0;
            // Only a plain 7-bit match answers; general call and
            // 10-bit prefixes never match this address
            if (shreg[7:1] == own_addr)
            begin
              next_rw = shreg[0];
              next_drv = 1'b1;
              next_state = ST_ADDR_ACK;
            end
            else
            begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          if (rw)
          begin
            next_shreg = rd_byte(ptr);
            next_drv = ~next_shreg[7];
            next_ptr = ptr + 8'h1;
            next_state = ST_RDATA;
          end
          else
          begin
            next_drv = 1'b0;
            next_state = ST_PTR;
          end
        end
        ST_PTR:
        begin
          if (byte_done)
          begin
            next_ptr = shreg;
            next_bitcnt = 4'h0;
            next_drv = 1'b1;
            next_state = ST_PTR_ACK;
          end
        end
        ST_PTR_ACK:
        begin
          next_drv = 1'b0;
          next_state = ST_WDATA;
        end
        ST_WDATA:
        begin
          if (byte_done)
          begin
            i2c_wr = 1'b1;
            next_ptr = ptr + 8'h1;
            next_bitcnt = 4'h0;
            next_drv = 1'b1;
            next_state = ST_WDATA_ACK;
          end
        end
        ST_WDATA_ACK:
        begin
          next_drv = 1'b0;
          next_state = ST_WDATA;
        end
        ST_RDATA:
        begin
          if (byte_done)
          begin
            next_bitcnt = 4'h0;
            next_drv = 1'b0;
            next_state = ST_RDATA_ACK;
          end
          else
          begin
            next_shreg = {shreg[6:0], 1'b0};
            next_drv = ~shreg[6];
          end
        end
        ST_RDATA_NEXT:
        begin
          next_shreg = rd_byte(ptr);
          next_drv = ~next_shreg[7];
          next_ptr = ptr + 8'h1;
          next_state = ST_RDATA;
        end
        default:
          next_state = state;
      endcase
    end
  end

  // Target state registers; never drives the clock line
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      drv <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end
    else
    begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      rw <= next_rw;
      drv <= next_drv;
      scl_q <= scl_i;
      sda_q <= sda_i;
      scl_p <= scl_q;
      sda_p <= sda_q;
    end
  end

  // Write path shared by both hosts
  assign wr_en = spi_mode ? spi_wr_i : i2c_wr;
  assign wr_addr = spi_mode ? spi_addr_i : ptr;
  assign wr_data = spi_mode ? spi_wdata_i : shreg;

  // Mode, address strap, baseline and register map next values
  always_comb
  begin
    next_spi_mode = spi_mode;
    next_addr_lsb = addr_lsb;
    next_booted = 1'b1;
    next_reload = 1'b0;
    next_bl_wr = baseline_valid_i;
    next_bl_data = bl_data;
    next_temp_reg = temp_reg;
    next_rh_reg = rh_reg;
    next_spi_rdata = rd_byte(spi_addr_i);
    // Sticky: later select levels are ignored
    if (!interface_select_n_i)
      next_spi_mode = 1'b1;
    // Strap caught on the first edge after release
    if (!booted)
    begin
      next_addr_lsb = addr_sel_i;
      next_reload = 1'b1;
    end
    if (baseline_valid_i)
      next_bl_data = baseline_i;
    if (wr_en)
    begin
      // Host-written compensation inputs; status is read-only
      case (wr_addr)
        `GSHP_REG_TEMP_L: next_temp_reg[7:0] = wr_data;
        `GSHP_REG_TEMP_H: next_temp_reg[15:8] = wr_data;
        `GSHP_REG_RH_L: next_rh_reg[7:0] = wr_data;
        `GSHP_REG_RH_H: next_rh_reg[15:8] = wr_data;
        default: next_temp_reg = temp_reg;
      endcase
    end
  end

  // Mode and map registers, cleared only by power-on reset
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      spi_mode <= 1'b0;
      addr_lsb <= 1'b0;
      booted <= 1'b0;
      reload <= 1'b0;
      bl_wr <= 1'b0;
      bl_data <= 16'h0000;
      temp_reg <= 16'h0000;
      rh_reg <= 16'h0000;
      spi_rdata <= 8'h00;
    end
    else
    begin
      spi_mode <= next_spi_mode;
      addr_lsb <= next_addr_lsb;
      booted <= next_booted;
      reload <= next_reload;
      bl_wr <= next_bl_wr;
      bl_data <= next_bl_data;
      temp_reg <= next_temp_reg;
      rh_reg <= next_rh_reg;
      spi_rdata <= next_spi_rdata;
    end
  end

  // Open-drain data line: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = drv;
  assign spi_mode_o = spi_mode;
  assign spi_rdata_o = spi_rdata;
  assign nvm_startup_commit_o = st_if.startup_commit;
  assign nvm_baseline_wr_o = bl_wr;
  assign nvm_baseline_o = bl_data;
  assign baseline_reload_o = reload;
  assign comp_temp_o = temp_reg;
  assign comp_rh_o = rh_reg;
  // Processed outputs compensated by default, raw values left alone
  assign comp_processed_en_o = 1'b1;
  assign comp_raw_en_o = 1'b0;

endmodule : gshp_top

`default_nettype wire

// File: gshp_top_chk.sv
// Checker for the host port: timing relations between its own pins.
// Assumes binding onto gshp_top; one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none

module gshp_top_chk (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic interface_select_n_i,
  input wire logic scl_i,
  input wire logic sda_oe_o,
  input wire logic spi_mode_o,
  input wire logic [7:0] spi_addr_i,
  input wire logic [7:0] spi_rdata_o,
  input wire logic nvm_startup_done_i,
  input wire logic nvm_startup_commit_o,
  input wire logic out_of_range_i,
  input wire logic [15:0] baseline_i,
  input wire logic baseline_valid_i,
  input wire logic nvm_baseline_wr_o,
  input wire logic [15:0] nvm_baseline_o,
  input wire logic baseline_reload_o,
  input wire logic comp_processed_en_o,
  input wire logic comp_raw_en_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [1:0] since_rel;
  logic [1:0] next_since_rel;
  logic [1:0] n_commit;
  logic [1:0] next_n_commit;

  // Saturating counts; two bits suffice since only 0, 1, 2 and "more" matter
  always_comb
  begin
    next_since_rel = (since_rel == 2'h3) ? since_rel : since_rel + 2'h1;
    next_n_commit = (nvm_startup_commit_o && n_commit != 2'h3) ? n_commit + 2'h1 : n_commit;
  end

  // Both restart at every power-on reset
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      since_rel <= 2'h0;
      n_commit <= 2'h0;
    end
    else
    begin
      since_rel <= next_since_rel;
      n_commit <= next_n_commit;
    end
  end

  a_baseline_capture: assert property (baseline_valid_i |=> nvm_baseline_wr_o
    && nvm_baseline_o == $past(baseline_i))
    else $error("baseline not stored one cycle after it came");
  a_baseline_quiet: assert property (!baseline_valid_i |=> !nvm_baseline_wr_o)
    else $error("baseline store without a new baseline");
  a_reload_pulse: assert property (baseline_reload_o |->
    (since_rel inside {2'h1, 2'h2}) ##1 !baseline_reload_o)
    else $error("baseline reload not a single early pulse");
  a_spi_sticky: assert property (spi_mode_o |=> spi_mode_o)
    else $error("spi mode left before reset");
  a_spi_enter: assert property (!interface_select_n_i |-> ##[0:3] spi_mode_o)
    else $error("select low did not choose spi mode");
  a_serial_off_spi: assert property (spi_mode_o [*3] |-> !sda_oe_o)
    else $error("data line driven in spi mode");
  a_drive_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i && $past(scl_i) == 1'b0)
    else $error("data line moved while clock high");
  a_comp_default: assert property (comp_processed_en_o && !comp_raw_en_o)
    else $error("compensation enables wrong");
  a_commit_once: assert property (n_commit < 2'h2)
    else $error("start-up commit repeated");
  a_commit_known: assert property (nvm_startup_done_i |-> !nvm_startup_commit_o)
    else $error("commit although start-up already done");
  a_status_fixed: assert property ($past(spi_addr_i) == 8'h20 |-> spi_rdata_o[7:4] == 4'h0
    && spi_rdata_o[1:0] == 2'h0)
    else $error("state report spare bits set");
  a_invalid_code: assert property ((out_of_range_i && spi_addr_i == 8'h20) [*3] |=>
    spi_rdata_o[3:2] == 2'h3)
    else $error("out of range not reported as code 3");
endmodule : gshp_top_chk

bind gshp_top gshp_top_chk gshp_top_chk_inst (
  .mclk_i, .rst_n_i, .interface_select_n_i, .scl_i, .sda_oe_o, .spi_mode_o, .spi_addr_i,
  .spi_rdata_o, .nvm_startup_done_i, .nvm_startup_commit_o, .out_of_range_i, .baseline_i,
  .baseline_valid_i, .nvm_baseline_wr_o, .nvm_baseline_o, .baseline_reload_o,
  .comp_processed_en_o, .comp_raw_en_o
);

`default_nettype wire

// File: gshp_top_tb.sv
// Self-checking bench for the host port: host model on the serial pins,
// direct drive of the SPI-side port and of the algorithm and NVM pins.
`timescale 1ns/1ps
`default_nettype none
`include "gshp_consts.svh"

module gshp_top_tb;
  import gshp_pkg::*;
  localparam int TK = 10;
  logic mclk_i, rst_n_i, interface_select_n_i, addr_sel_i, scl_i, sda_i, sda_o, sda_oe_o;
  logic spi_mode_o, spi_wr_i, nvm_startup_done_i, nvm_startup_commit_o, out_of_range_i;
  logic baseline_valid_i, nvm_baseline_wr_o, baseline_reload_o, comp_processed_en_o;
  logic comp_raw_en_o, sda_pull, strap, ack;
  logic [7:0] spi_addr_i, spi_wdata_i, spi_rdata_o, rd;
  logic [15:0] baseline_i, nvm_baseline_o, comp_temp_o, comp_rh_o, val16;
  logic [7:0] wd [4];
  logic [7:0] bad [3] = '{8'h00, 8'hf0, 8'hf8};
  int fails = 0, n_compared = 0, cycles = 0, up = 0, reloads = 0, commits = 0;
  int seed = 32'h25c4869a;

  gshp_top #(.TICK_CYCLES(TK), .WARMUP_S(3), .STARTUP_S(6), .COMMIT_S(9)) gshp_top_inst (
    .mclk_i, .rst_n_i, .interface_select_n_i, .addr_sel_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
    .spi_mode_o, .spi_addr_i, .spi_wr_i, .spi_wdata_i, .spi_rdata_o, .nvm_startup_done_i,
    .nvm_startup_commit_o, .out_of_range_i, .baseline_i, .baseline_valid_i, .nvm_baseline_wr_o,
    .nvm_baseline_o, .baseline_reload_o, .comp_temp_o, .comp_rh_o, .comp_processed_en_o,
    .comp_raw_en_o
  );
  gshp_host_bfm gshp_host_bfm_inst (.mclk_i, .sda_i, .scl_o(scl_i), .sda_pull_o(sda_pull));

  // Open-drain data line with pull-up: low when either side pulls
  assign sda_i = ~sda_pull & ~(sda_oe_o & ~sda_o);

  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic give_verdict();
    if (fails == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [7:0] dev_addr(input logic rw);
    return {`GSHP_ADDR_HI6, strap, rw};
  endfunction : dev_addr
  function automatic logic [7:0] exp_status(input logic [1:0] v);
    return 8'(v) << `GSHP_VALID_LSB;
  endfunction : exp_status
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick

  // Power-on reset with a fresh random address strap
  task automatic power_up(input logic done);
    tick(1);
    rst_n_i <= 1'b0;
    nvm_startup_done_i <= done;
    strap = 1'($random(seed));
    addr_sel_i <= strap;
    reloads = 0;
    commits = 0;
    tick(16);
    rst_n_i <= 1'b1;
  endtask : power_up

  // Reads the state report on the SPI-side port at a cycle after release
  task automatic status_at(input int t, input logic [1:0] v);
    while (up < t)
      @(posedge mclk_i);
    #1;
    check("validity", spi_rdata_o, exp_status(v));
    @(posedge mclk_i);
  endtask : status_at
  // Write-direction address then register pointer
  task automatic i2c_head(input logic [7:0] ptr);
    gshp_host_bfm_inst.start_cond();
    gshp_host_bfm_inst.wbyte(dev_addr(1'b0), ack);
    check("address ack", ack, 1'b1);
    gshp_host_bfm_inst.wbyte(ptr, ack);
    check("pointer ack", ack, 1'b1);
  endtask : i2c_head

  // Cycle bookkeeping, pulse counting and the hang limit
  always @(posedge mclk_i)
  begin
    cycles++;
    up = rst_n_i ? up + 1 : 0;
    if (baseline_reload_o)
      reloads++;
    if (nvm_startup_commit_o)
      commits++;
    if (cycles == 20000)
    begin
      fails++;
      give_verdict();
    end
  end

  initial
  begin
    rst_n_i <= 1'b0;
    interface_select_n_i <= 1'b1;
    addr_sel_i <= 1'b0;
    spi_addr_i <= `GSHP_REG_STATUS;
    spi_wr_i <= 1'b0;
    spi_wdata_i <= 8'h00;
    nvm_startup_done_i <= 1'b0;
    out_of_range_i <= 1'b0;
    baseline_i <= 16'h0000;
    baseline_valid_i <= 1'b0;
    // First run cut short before the commit time
    power_up(1'b0);
    status_at(5, `GSHP_VAL_STARTUP);
    status_at(7 * TK + 5, `GSHP_VAL_OK);
    check("early commit", commits[15:0], 16'h0);
    check("reloads", reloads[15:0], 16'h1);
    power_up(1'b0);
    status_at(4 * TK + 5, `GSHP_VAL_STARTUP);
    out_of_range_i <= 1'b1;
    status_at(10 * TK, `GSHP_VAL_INVALID);
    out_of_range_i <= 1'b0;
    status_at(12 * TK + 5, `GSHP_VAL_OK);
    check("commit count", commits[15:0], 16'h1);
    // Start-up already recorded: warm-up only
    power_up(1'b1);
    status_at(5, `GSHP_VAL_WARMUP);
    status_at(4 * TK + 5, `GSHP_VAL_OK);
    baseline_i <= 16'($random(seed));
    baseline_valid_i <= 1'b1;
    tick(1);
    baseline_valid_i <= 1'b0;
    tick(2);
    check("baseline store", nvm_baseline_o, baseline_i);
    // Burst write over both compensation registers
    for (int i = 0; i < 4; i++)
      wd[i] = 8'($random(seed));
    i2c_head(`GSHP_REG_TEMP_L);
    for (int i = 0; i < 4; i++)
    begin
      gshp_host_bfm_inst.wbyte(wd[i], ack);
      check("data ack", ack, 1'b1);
    end
    gshp_host_bfm_inst.stop_cond();
    check("temperature", comp_temp_o, {wd[1], wd[0]});
    check("humidity", comp_rh_o, {wd[3], wd[2]});
    // Read back through a repeated start
    i2c_head(`GSHP_REG_TEMP_L);
    gshp_host_bfm_inst.start_cond();
    gshp_host_bfm_inst.wbyte(dev_addr(1'b1), ack);
    check("read address ack", ack, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      gshp_host_bfm_inst.rbyte(i < 3, rd);
      check("read data", rd, wd[i]);
    end
    gshp_host_bfm_inst.stop_cond();
    // State report seen from the serial side too
    i2c_head(`GSHP_REG_STATUS);
    gshp_host_bfm_inst.start_cond();
    gshp_host_bfm_inst.wbyte(dev_addr(1'b1), ack);
    gshp_host_bfm_inst.rbyte(1'b0, rd);
    gshp_host_bfm_inst.stop_cond();
    check("serial state report", rd, exp_status(`GSHP_VAL_OK));
    // Other address, general call, 10-bit prefix, device ID: all ignored
    for (int i = 0; i < 4; i++)
    begin
      gshp_host_bfm_inst.start_cond();
      gshp_host_bfm_inst.wbyte(i == 3 ? dev_addr(1'b0) ^ 8'h02 : bad[i], ack);
      gshp_host_bfm_inst.stop_cond();
      check("foreign address ack", ack, 1'b0);
    end
    // SPI-side write refused before the select pin goes low
    spi_addr_i <= `GSHP_REG_TEMP_L;
    spi_wdata_i <= ~wd[0];
    spi_wr_i <= 1'b1;
    tick(1);
    spi_wr_i <= 1'b0;
    tick(2);
    check("temperature kept", comp_temp_o, {wd[1], wd[0]});
    interface_select_n_i <= 1'b0;
    tick(2);
    interface_select_n_i <= 1'b1;
    tick(4);
    check("spi mode", spi_mode_o, 1'b1);
    val16 = 16'($random(seed));
    spi_addr_i <= `GSHP_REG_RH_L;
    spi_wdata_i <= val16[7:0];
    spi_wr_i <= 1'b1;
    tick(1);
    spi_addr_i <= `GSHP_REG_RH_H;
    spi_wdata_i <= val16[15:8];
    tick(1);
    spi_wr_i <= 1'b0;
    spi_addr_i <= `GSHP_REG_RH_L;
    tick(2);
    check("humidity via spi", comp_rh_o, val16);
    check("spi read", spi_rdata_o, val16[7:0]);
    // Serial side stays deaf once SPI is chosen
    gshp_host_bfm_inst.start_cond();
    gshp_host_bfm_inst.wbyte(dev_addr(1'b0), ack);
    gshp_host_bfm_inst.stop_cond();
    check("ack in spi mode", ack, 1'b0);
    check("commit when done", commits[15:0], 16'h0);
    give_verdict();
  end
endmodule : gshp_top_tb

`default_nettype wire
